/* File: rtl/tla_monitor.sv */
// two-channel temperature monitor core with limit alarms
`timescale 1ns/1ps
module tla_monitor
	import tla_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A, // arbitrary value
	parameter int         CONV_CYCLES = CONV_CYC,
	parameter int         GAP_CYCLES  = GAP_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output wire logic       o_sda,
	output wire logic       o_sda_oe_n,
	input  wire logic [9:0] i_adc_temp,
	input  wire logic       i_diode_open,
	output wire logic       o_sel_remote,
	output wire logic       o_adc_start,
	output wire logic       o_overtemp_out,
	output wire logic       o_overtemp_out_oe_n,
	output wire logic       o_alarm_or_second_overtemp_pin,
	output wire logic       o_alarm_or_second_overtemp_pin_oe_n
);
	localparam int CW = $clog2(CONV_CYCLES + GAP_CYCLES + 1);
	localparam logic [CW-1:0] CONV_END = CW'(CONV_CYCLES - 1);
	localparam logic [CW-1:0] GAP_END  = CW'(GAP_CYCLES - 1);

	// ************************************************************
	// host register access
	// ************************************************************
	logic       wr_stb;
	logic [7:0] ptr, wr_data, rd_data;
	logic [7:0] cfg_q;
	logic [7:0] lim_q [8];
	logic [7:0] val_q [2];
	logic       lh_q, ll_q, rh_q, rl_q, open_q, lot_q, rot_q;

	tla_smb_slave #(
		.SLAVE_ADDR (SLAVE_ADDR)
	) u_smb (
		.i_clk_sys  (i_clk_sys),
		.i_srst     (i_srst),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda_oe_n (o_sda_oe_n),
		.o_wr_stb   (wr_stb),
		.o_ptr      (ptr),
		.o_wr_data  (wr_data),
		.i_rd_data  (rd_data)
	);

	wire       ptr_is_lim = (ptr >= PTR_LIM_BASE) && (ptr <= PTR_LIM_LAST);
	wire [7:0] lim_ofs = ptr - PTR_LIM_BASE;
	wire [2:0] lim_idx = lim_ofs[2:0];
	wire       cfg_wr = wr_stb && (ptr == PTR_CONFIG);
	wire       lim_wr = wr_stb && ptr_is_lim;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst)
			cfg_q <= CFG_RST;
		else if (cfg_wr)
			cfg_q <= wr_data & CFG_WR_MASK;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_lim
			always_ff @(posedge i_clk_sys) begin
				if (i_srst)
					lim_q[gi] <= LIM_RST[gi];
				else if (lim_wr && (lim_idx == 3'(gi)))
					lim_q[gi] <= wr_data;
			end
		end
	endgenerate

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	tla_seq_t      seq_q;
	logic [CW-1:0] cnt_q;
	logic          remote_q;

	wire eoc = (seq_q == SEQ_CONV) && (cnt_q == CONV_END);
	wire gap_end = (seq_q == SEQ_GAP) && (cnt_q == GAP_END);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			seq_q    <= SEQ_CONV;
			cnt_q    <= '0;
			remote_q <= 1'b0;
		end else begin
			case (seq_q)
			SEQ_CONV: begin
				cnt_q <= eoc ? '0 : cnt_q + 1'b1;
				if (eoc)
					seq_q <= SEQ_GAP;
			end
			SEQ_GAP: begin
				cnt_q <= gap_end ? '0 : cnt_q + 1'b1;
				if (gap_end) begin
					seq_q    <= SEQ_CONV;
					remote_q <= ~remote_q;
				end
			end
			default: begin
				seq_q <= SEQ_CONV;
				cnt_q <= '0;
			end
			endcase
		end
	end

	assign o_sel_remote = remote_q;
	assign o_adc_start  = (seq_q == SEQ_CONV) && (cnt_q == '0);

	// ************************************************************
	// result encoding
	// ************************************************************
	wire [7:0]  ofs = lim_q[LIM_REMOTE_OFS];
	wire [10:0] ofs_ext = remote_q ? {{3{ofs[7]}}, ofs} : 11'h000;
	wire [10:0] t_adj = {i_adc_temp[9], i_adc_temp} + ofs_ext;
	wire [10:0] t_off = t_adj + OFFSET_ADD;
	wire        bin_neg = t_adj[10];
	wire        bin_big = !t_adj[10] && (t_adj[9:0] > {2'h0, BIN_MAX});
	wire        off_neg = t_off[10];
	wire        off_big = !t_off[10] && (t_off[9:0] > {2'h0, OFFSET_MAX});
	wire [7:0]  code_bin = bin_neg ? 8'h00 :
		bin_big ? BIN_MAX : t_adj[7:0];
	wire [7:0]  code_off = off_neg ? 8'h00 :
		off_big ? OFFSET_MAX : t_off[7:0];
	wire        fmt_off = cfg_q[CFG_OFFSET_FMT_BIT];
	wire [7:0]  code = fmt_off ? code_off : code_bin;

	logic upd_q, upd_rem_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			val_q[0]  <= 8'h00;
			val_q[1]  <= 8'h00;
			upd_q     <= 1'b0;
			upd_rem_q <= 1'b0;
			open_q    <= 1'b0;
		end else begin
			upd_q <= eoc;
			if (eoc) begin
				val_q[remote_q] <= code;
				upd_rem_q       <= remote_q;
				if (remote_q)
					open_q <= i_diode_open;
			end
		end
	end

	// ************************************************************
	// limit comparison and flags
	// ************************************************************
	wire [7:0] cur = val_q[upd_rem_q];
	wire [7:0] hi_lim = upd_rem_q ? lim_q[LIM_REMOTE_HIGH] :
		lim_q[LIM_LOCAL_HIGH];
	wire [7:0] lo_lim = upd_rem_q ? lim_q[LIM_REMOTE_LOW] :
		lim_q[LIM_LOCAL_LOW];
	wire [7:0] ov_lim = upd_rem_q ? lim_q[LIM_REMOTE_OVER] :
		lim_q[LIM_LOCAL_OVER];
	wire [7:0] hyst = lim_q[LIM_OVER_HYST];
	wire [7:0] ov_rel = (ov_lim > hyst) ? ov_lim - hyst : 8'h00;
	wire       over_hi = cur > hi_lim;
	wire       under_lo = cur < lo_lim;
	wire       ov_set = cur > ov_lim;
	wire       ov_clr = cur <= ov_rel;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			{lh_q, ll_q, rh_q, rl_q} <= 4'h0;
			{lot_q, rot_q}           <= 2'h0;
		end else if (upd_q && !upd_rem_q) begin
			lh_q  <= over_hi;
			ll_q  <= under_lo;
			lot_q <= ov_set | (lot_q & ~ov_clr);
		end else if (upd_q) begin
			rh_q  <= over_hi;
			rl_q  <= under_lo;
			rot_q <= ov_set | (rot_q & ~ov_clr);
		end
	end

	wire busy = (seq_q == SEQ_CONV);
	wire [7:0] status = {busy, lh_q, ll_q, rh_q, rl_q, open_q, 2'h0};

	assign rd_data = (ptr == PTR_LOCAL_VAL)  ? val_q[0] :
		(ptr == PTR_REMOTE_VAL) ? val_q[1] :
		(ptr == PTR_STATUS)     ? status :
		(ptr == PTR_CONFIG)     ? cfg_q :
		ptr_is_lim              ? lim_q[lim_idx] : 8'h00;

	// ************************************************************
	// open-drain alarm outputs
	// ************************************************************
	logic ot_oe_n_q, al_oe_n_q;

	wire second_mode = cfg_q[CFG_SECOND_OVER_BIT];
	wire alarm_int = lh_q | ll_q | rh_q | rl_q | open_q;
	wire alarm_ot2 = lh_q | rh_q;
	wire alarm_act = second_mode ? alarm_ot2 : alarm_int;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ot_oe_n_q <= 1'b1;
			al_oe_n_q <= 1'b1;
		end else begin
			ot_oe_n_q <= ~(lot_q | rot_q);
			al_oe_n_q <= ~alarm_act;
		end
	end

	assign o_sda                               = 1'b0;
	assign o_overtemp_out                      = 1'b0;
	assign o_overtemp_out_oe_n                 = ot_oe_n_q;
	assign o_alarm_or_second_overtemp_pin      = 1'b0;
	assign o_alarm_or_second_overtemp_pin_oe_n = al_oe_n_q;
endmodule // tla_monitor

/* File: rtl/tla_pkg.sv */
// shared constants and types of the temperature limit alarm monitor
package tla_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_HZ       = 20_000_000;
	localparam int CONV_TIME_NS = 100_000;
	localparam int GAP_TIME_NS  = 50_000;
	localparam int CONV_CYC     = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999)
		/ 1000;
	localparam int GAP_CYC      = (GAP_TIME_NS * (CLK_HZ / 1_000_000) + 999)
		/ 1000;

	// ************************************************************
	// register pointer map
	// ************************************************************
	localparam logic [7:0] PTR_LOCAL_VAL  = 8'h00;
	localparam logic [7:0] PTR_REMOTE_VAL = 8'h01;
	localparam logic [7:0] PTR_STATUS     = 8'h02;
	localparam logic [7:0] PTR_CONFIG     = 8'h03;
	localparam logic [7:0] PTR_LIM_BASE   = 8'h04;
	localparam logic [7:0] PTR_LIM_LAST   = 8'h0B;

	// limit array entries
	localparam logic [2:0] LIM_LOCAL_HIGH  = 3'h0;
	localparam logic [2:0] LIM_LOCAL_LOW   = 3'h1;
	localparam logic [2:0] LIM_REMOTE_HIGH = 3'h2;
	localparam logic [2:0] LIM_REMOTE_LOW  = 3'h3;
	localparam logic [2:0] LIM_LOCAL_OVER  = 3'h4;
	localparam logic [2:0] LIM_REMOTE_OVER = 3'h5;
	localparam logic [2:0] LIM_OVER_HYST   = 3'h6;
	localparam logic [2:0] LIM_REMOTE_OFS  = 3'h7;

	// limit reset values, indexed by entry
	localparam logic [7:0] LIM_RST [8] = '{8'h55, 8'h00, 8'h55, 8'h00,
		8'h55, 8'h55, 8'h0A, 8'h00};

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int         CFG_SECOND_OVER_BIT = 5;
	localparam int         CFG_OFFSET_FMT_BIT  = 2;
	localparam logic [7:0] CFG_RST             = 8'h00;
	localparam logic [7:0] CFG_WR_MASK         = 8'h24;
	localparam int         ST_BUSY_BIT         = 7;
	localparam int         ST_LOCAL_HIGH_BIT   = 6;
	localparam int         ST_LOCAL_LOW_BIT    = 5;
	localparam int         ST_REMOTE_HIGH_BIT  = 4;
	localparam int         ST_REMOTE_LOW_BIT   = 3;
	localparam int         ST_OPEN_BIT         = 2;
	localparam logic [7:0] BIN_MAX             = 8'h7F;
	localparam logic [7:0] OFFSET_MAX          = 8'hFF;
	localparam logic [10:0] OFFSET_ADD         = 11'h040;

	// ************************************************************
	// state types
	// ************************************************************
	typedef enum logic [0:0] {SEQ_CONV, SEQ_GAP} tla_seq_t;
	typedef enum logic [2:0] {SMB_IDLE, SMB_ADDR, SMB_PTR, SMB_WR, SMB_RD,
		SMB_ACK, SMB_MACK, SMB_IGNORE} tla_smb_t;
endpackage

/* File: rtl/tla_smb_slave.sv */
// serial bus slave giving register access to the monitor core
`timescale 1ns/1ps
module tla_smb_slave
	import tla_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A // arbitrary value
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output wire logic       o_sda_oe_n,
	output wire logic       o_wr_stb,
	output wire logic [7:0] o_ptr,
	output wire logic [7:0] o_wr_data,
	input  wire logic [7:0] i_rd_data
);
	// ************************************************************
	// pin synchronisers and bus events
	// ************************************************************
	logic     scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	tla_smb_t st_q, next_q;
	logic [2:0] cnt_q;
	logic [7:0] shift_q, ptr_q, wdat_q;
	logic       drive_q, ack_done_q, wr_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			{scl_p, scl_s, scl_m} <= 3'h7;
			{sda_p, sda_s, sda_m} <= 3'h7;
		end else begin
			{scl_p, scl_s, scl_m} <= {scl_s, scl_m, i_scl};
			{sda_p, sda_s, sda_m} <= {sda_s, sda_m, i_sda};
		end
	end

	wire       scl_rise = scl_s & ~scl_p;
	wire       scl_fall = ~scl_s & scl_p;
	wire       bus_start = scl_s & scl_p & sda_p & ~sda_s;
	wire       bus_stop = scl_s & scl_p & ~sda_p & sda_s;
	wire [7:0] byte_in = {shift_q[6:0], sda_s};
	wire       last_bit = (cnt_q == 3'h7);
	wire       addr_hit = (byte_in[7:1] == SLAVE_ADDR);

	// ************************************************************
	// byte engine
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			st_q       <= SMB_IDLE;
			next_q     <= SMB_IDLE;
			cnt_q      <= 3'h0;
			shift_q    <= 8'h00;
			ptr_q      <= 8'h00;
			wdat_q     <= 8'h00;
			drive_q    <= 1'b0;
			ack_done_q <= 1'b0;
			wr_q       <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (bus_start) begin
				st_q    <= SMB_ADDR;
				cnt_q   <= 3'h0;
				drive_q <= 1'b0;
			end else if (bus_stop) begin
				st_q    <= SMB_IDLE;
				drive_q <= 1'b0;
			end else if (scl_rise) begin
				case (st_q)
				SMB_ADDR, SMB_PTR, SMB_WR: begin
					shift_q <= byte_in;
					cnt_q   <= cnt_q + 3'h1;
					if (last_bit) begin
						st_q       <= SMB_ACK;
						ack_done_q <= 1'b0;
						if (st_q == SMB_ADDR) begin
							if (!addr_hit)
								st_q <= SMB_IGNORE;
							next_q <= byte_in[0] ? SMB_RD : SMB_PTR;
						end else if (st_q == SMB_PTR) begin
							ptr_q  <= byte_in;
							next_q <= SMB_WR;
						end else begin
							wdat_q <= byte_in;
							wr_q   <= 1'b1;
							next_q <= SMB_WR;
						end
					end
				end
				SMB_RD: begin
					cnt_q <= cnt_q + 3'h1;
					if (last_bit)
						st_q <= SMB_MACK;
				end
				SMB_MACK: begin
					if (sda_s) begin
						st_q <= SMB_IGNORE;
					end else begin
						st_q    <= SMB_RD;
						shift_q <= i_rd_data;
					end
				end
				default: begin
				end
				endcase
			end else if (scl_fall) begin
				case (st_q)
				SMB_ACK: begin
					if (!ack_done_q) begin
						drive_q    <= 1'b1;
						ack_done_q <= 1'b1;
					end else begin
						st_q  <= next_q;
						cnt_q <= 3'h0;
						drive_q <= 1'b0;
						if (next_q == SMB_RD) begin
							drive_q <= ~i_rd_data[7];
							shift_q <= {i_rd_data[6:0], 1'b0};
						end
					end
				end
				SMB_RD: begin
					drive_q <= ~shift_q[7];
					shift_q <= {shift_q[6:0], 1'b0};
				end
				default: drive_q <= 1'b0;
				endcase
			end
		end
	end

	assign o_sda_oe_n = ~drive_q;
	assign o_wr_stb   = wr_q;
	assign o_ptr      = ptr_q;
	assign o_wr_data  = wdat_q;
endmodule // tla_smb_slave

/* File: test/tla_monitor_properties.sv */
// port checks of the temperature limit alarm monitor
`timescale 1ns/1ps
module tla_monitor_properties
	import tla_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR  = 7'h2A, // arbitrary value
	parameter int         CONV_CYCLES = CONV_CYC,
	parameter int         GAP_CYCLES  = GAP_CYC
) (
	input wire logic       i_clk_sys,
	input wire logic       i_srst,
	input wire logic       i_scl,
	input wire logic       i_sda,
	input wire logic       o_sda,
	input wire logic       o_sda_oe_n,
	input wire logic [9:0] i_adc_temp,
	input wire logic       i_diode_open,
	input wire logic       o_sel_remote,
	input wire logic       o_adc_start,
	input wire logic       o_overtemp_out,
	input wire logic       o_overtemp_out_oe_n,
	input wire logic       o_alarm_or_second_overtemp_pin,
	input wire logic       o_alarm_or_second_overtemp_pin_oe_n
);
	// ****************
	// assertions
	// ****************
	localparam int PER = CONV_CYCLES + GAP_CYCLES;
	localparam int PIN = CONV_CYCLES + 2;
	localparam int EOC = CONV_CYCLES - 1;
	wire logic st_run = o_adc_start & ~i_srst;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	a_conv_free_run: assert property (
		o_adc_start |-> ##PER o_adc_start)
		else $error("conversion did not restart");
	a_start_pulse: assert property (o_adc_start |=> !o_adc_start)
		else $error("start longer than one cycle");
	a_sel_toggles: assert property (
		o_adc_start |-> ##PER $changed(o_sel_remote))
		else $error("channel did not alternate");
	a_hot_overtemp: assert property (
		$past(st_run, EOC) && $signed(i_adc_temp) > 10'sh055
		|-> ##3 !o_overtemp_out_oe_n)
		else $error("overtemp pin not low");
	a_ot_update_time: assert property (
		$changed(o_overtemp_out_oe_n) |-> $past(st_run, PIN))
		else $error("overtemp pin moved off conversion");
	a_reset_release: assert property (
		disable iff (1'b0) i_srst |=> o_sda_oe_n && o_overtemp_out_oe_n
		&& !o_sel_remote && o_alarm_or_second_overtemp_pin_oe_n)
		else $error("pins not released in reset");
	a_drive_low_only: assert property (
		!o_sda && !o_overtemp_out && !o_alarm_or_second_overtemp_pin)
		else $error("open drain pin driven high");
	a_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
		else $error("data changed while clock high");
	c_remote_conv: cover property (o_adc_start && o_sel_remote);
	c_alarm_low: cover property ($fell(o_alarm_or_second_overtemp_pin_oe_n));
	c_sda_drive: cover property ($fell(o_sda_oe_n));
endmodule // tla_monitor_properties

bind tla_monitor tla_monitor_properties #(.SLAVE_ADDR(SLAVE_ADDR),
	.CONV_CYCLES(CONV_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_props (.*);

/* File: test/tla_smb_host.sv */
// behavioural serial bus host for the monitor's register port
`timescale 1ns/1ps
module tla_smb_host (
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_drv_n
);
	// ****************
	// bus conditions
	// ****************
	initial begin
		o_scl       = 1'b1;
		o_sda_drv_n = 1'b1;
	end
	// start or repeated start, clock left low
	task automatic start();
		#7;
		o_sda_drv_n = 1'b1;
		#100;
		o_scl = 1'b1;
		#600;
		o_sda_drv_n = 1'b0;
		#600;
		o_scl = 1'b0;
		#100;
	endtask
	// one bit, data changed only while clock low
	task automatic put_bit(input logic b, output logic r);
		o_sda_drv_n = b;
		#125;
		o_scl = 1'b1;
		#75;
		r = i_sda;
		#75;
		o_scl = 1'b0;
		#125;
	endtask
	// byte msb first, line released for acknowledge
	task automatic xfer(input logic [7:0] d, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], r[i]);
		end
		put_bit(1'b1, a);
	endtask
	task automatic stop();
		o_sda_drv_n = 1'b0;
		#125;
		o_scl = 1'b1;
		#600;
		o_sda_drv_n = 1'b1;
		#600;
	endtask
endmodule // tla_smb_host

/* File: test/tla_monitor_bench.sv */
// self-checking bench of the temperature limit alarm monitor
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tla_monitor_bench import tla_pkg::*;;
	// ****************
	// signals
	// ****************
	localparam logic [6:0] SLAVE_A = 7'h2A; // arbitrary value
	logic              i_clk_sys;
	logic              i_srst;
	logic              i_diode_open;
	logic        [9:0] i_adc_temp;
	logic signed [9:0] loc_t;
	logic signed [9:0] rem_t;
	logic              open_t;
	logic              host_drv_n;
	logic        [7:0] q;
	int                num_errors;
	int                n_checks;
	int                cyc = 0;
	wire logic         i_scl;
	wire logic         i_sda;
	wire logic         o_sda;
	wire logic         o_sda_oe_n;
	wire logic         o_sel_remote;
	wire logic         o_adc_start;
	wire logic         o_overtemp_out;
	wire logic         o_overtemp_out_oe_n;
	wire logic         o_alarm_or_second_overtemp_pin;
	wire logic         o_alarm_or_second_overtemp_pin_oe_n;
	wire logic         alarm_n = o_alarm_or_second_overtemp_pin_oe_n;
	assign i_sda = host_drv_n & (o_sda_oe_n | o_sda);
	tla_monitor #(.SLAVE_ADDR(SLAVE_A), .CONV_CYCLES(20),
		.GAP_CYCLES(10)) uut (
		.i_clk_sys, .i_srst, .i_scl, .i_sda, .o_sda, .o_sda_oe_n,
		.i_adc_temp, .i_diode_open, .o_sel_remote, .o_adc_start,
		.o_overtemp_out, .o_overtemp_out_oe_n,
		.o_alarm_or_second_overtemp_pin,
		.o_alarm_or_second_overtemp_pin_oe_n);
	tla_smb_host u_host (.i_sda, .o_scl(i_scl), .o_sda_drv_n(host_drv_n));
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		i_adc_temp   <= o_sel_remote ? rem_t : loc_t;
		i_diode_open <= open_t;
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	// ****************
	// register access
	// ****************
	task automatic xb(input logic [7:0] d, input logic e);
		logic a;
		u_host.xfer(d, q, a);
		`CHK("ack", e, a)
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(posedge i_clk_sys);
		u_host.start();
		xb({SLAVE_A, 1'b0}, 1'b0);
		xb(p, 1'b0);
		xb(d, 1'b0);
		u_host.stop();
	endtask
	task automatic rd(input logic [7:0] p, m, e);
		@(posedge i_clk_sys);
		u_host.start();
		xb({SLAVE_A, 1'b0}, 1'b0);
		xb(p, 1'b0);
		u_host.start();
		xb({SLAVE_A, 1'b1}, 1'b0);
		xb(8'hFF, 1'b1);
		u_host.stop();
		`CHK("reg", e, q & m)
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		`CHK("alarm", 1'b1, alarm_n)
		`CHK("ovt", 1'b1, o_overtemp_out_oe_n)
		rd(PTR_CONFIG, 8'hFF, CFG_RST);
		u_host.start();
		xb({~SLAVE_A, 1'b0}, 1'b1);
		u_host.stop();
		wr(PTR_CONFIG, 8'hFF);
		rd(PTR_CONFIG, 8'hFF, 8'h24);
		wr(PTR_CONFIG, CFG_RST);
		for (int i = 0; i < 8; i++) begin
			rd(PTR_LIM_BASE + 8'(i), 8'hFF, LIM_RST[i]);
		end
		rd(8'h0C, 8'hFF, 8'h00);
	endtask
	task automatic t_binary();
		loc_t = 10'h3FB;
		rem_t = 10'h0C8;
		repeat (130) @(posedge i_clk_sys);
		rd(PTR_LOCAL_VAL, 8'hFF, 8'h00);
		rd(PTR_REMOTE_VAL, 8'hFF, BIN_MAX);
		rd(PTR_STATUS, 8'h7C, 8'h10);
		`CHK("ovt", 1'b0, o_overtemp_out_oe_n)
		`CHK("alarm", 1'b0, alarm_n)
	endtask
	task automatic t_offset();
		wr(PTR_CONFIG, 8'h04);
		loc_t = 10'h3C9;
		rem_t = 10'h096;
		repeat (130) @(posedge i_clk_sys);
		rd(PTR_LOCAL_VAL, 8'hFF, 8'h09);
		rd(PTR_REMOTE_VAL, 8'hFF, 8'hD6);
		rd(PTR_LIM_BASE, 8'hFF, LIM_RST[0]);
		wr(PTR_LIM_BASE + 8'h07, 8'hF6);
		repeat (130) @(posedge i_clk_sys);
		rd(PTR_REMOTE_VAL, 8'hFF, 8'hCC);
		wr(PTR_LIM_BASE + 8'h07, 8'h00);
		wr(PTR_CONFIG, 8'h00);
	endtask
	task automatic t_alarm();
		loc_t = 10'h014;
		rem_t = 10'h014;
		open_t = 1'b1;
		repeat (130) @(posedge i_clk_sys);
		`CHK("alarm", 1'b0, alarm_n)
		`CHK("ovt", 1'b1, o_overtemp_out_oe_n)
		wr(PTR_CONFIG, 8'h20);
		wr(PTR_LIM_BASE + 8'h01, 8'h1E);
		repeat (130) @(posedge i_clk_sys);
		rd(PTR_LIM_BASE + 8'h01, 8'hFF, 8'h1E);
		rd(PTR_STATUS, 8'h7C, 8'h24);
		`CHK("alarm", 1'b1, alarm_n)
		loc_t = 10'h064;
		repeat (130) @(posedge i_clk_sys);
		`CHK("alarm", 1'b0, alarm_n)
		`CHK("ovt", 1'b0, o_overtemp_out_oe_n)
	endtask
	task automatic finish_test();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		i_srst       = 1'b1;
		loc_t        = 10'h000;
		rem_t        = 10'h000;
		open_t       = 1'b0;
		num_errors   = 0;
		n_checks     = 0;
		repeat (12) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		t_reset();
		t_binary();
		t_offset();
		t_alarm();
		finish_test();
	end
endmodule // tla_monitor_bench
